// ---- l2_tag_and_cpu2_arbitration.sv ----
`timescale 1ns/100ps
// Purpose: Tag RAM control in L2 mode, second processor grants otherwise
// Assumes: Core requests are synchronous to clk; pins pass two flip-flops
// Notes: Shared pin line_modified_out_or_cpu2_grant is active low as a grant
module l2_tag_and_cpu2_arbitration import l2_tag_pkg::*; #(
	parameter int DLY_W = HIT_DLY_W_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cpu2_mode,
	input wire logic tag_status_polarity_select,
	input wire logic tag_read_hold_select,
	input wire logic [DLY_W-1:0] hit_sample_delay,
	input wire logic tag_lookup_active,
	input wire logic tag_write_req,
	input wire logic new_line_valid,
	input wire logic new_line_modified,
	input wire logic copy_back_tag_read_req,
	input wire logic address_phase_end,
	input wire logic higher_priority_pending,
	input wire logic data_bus_next_free,
	input wire logic cpu2_data_top_priority,
	input wire logic transfer_start_n,
	input wire logic line_modified_in_or_cpu2_request,
	output logic tag_write_strobe_n,
	output logic tag_line_valid_out,
	output logic tag_line_valid_oe,
	output logic tag_latch_output_enable_n,
	output logic line_modified_out_or_cpu2_grant,
	output logic tag_drive_enable_or_cpu2_data_grant_n,
	output logic tag_write_busy,
	output logic line_modified,
	output logic line_status_sampled,
	output logic cpu2_request_seen
);
	if (DLY_W < 1 || DLY_W > 8) begin : g_bad
		$error("hit delay width out of range");
	end

	tag_state_e state_r, state_nxt;
	logic mode_r;
	logic mode_taken_r;
	logic ts_s1_r, ts_s2_r, ts_s3_r;
	logic din_s1_r, din_s2_r;
	logic phase_open_r;
	logic wr_valid_r, wr_modified_r;
	logic wr_take;
	logic cb_take;
	logic ts_seen;
	logic req_active;
	logic cpu2;

	delay_timer_if #(.W(DLY_W)) hit_tif ();
	delay_timer_if #(.W(TOE_CNT_W)) toe_tif ();

	delay_timer #(.W(DLY_W)) u_hit_timer (
		.clk(clk),
		.reset(reset),
		.tif(hit_tif)
	);

	delay_timer #(.W(TOE_CNT_W)) u_toe_timer (
		.clk(clk),
		.reset(reset),
		.tif(toe_tif)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_r <= MODE_RESET;
			mode_taken_r <= 1'b0;
		end else if (!mode_taken_r) begin
			mode_r <= cpu2_mode;
			mode_taken_r <= 1'b1;
		end
	end
	assign cpu2 = mode_r;

	// Pin synchronisers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ts_s1_r <= 1'b1;
			ts_s2_r <= 1'b1;
			ts_s3_r <= 1'b1;
			din_s1_r <= 1'b0;
			din_s2_r <= 1'b0;
		end else begin
			ts_s1_r <= transfer_start_n;
			ts_s2_r <= ts_s1_r;
			ts_s3_r <= ts_s2_r;
			din_s1_r <= line_modified_in_or_cpu2_request;
			din_s2_r <= din_s1_r;
		end
	end
	assign ts_seen = !ts_s2_r && ts_s3_r;

	// Tag write / lookup sequencing
	assign wr_take = !cpu2 && tag_write_req && (state_r == ST_IDLE || state_r == ST_LOOKUP);
	assign cb_take = !cpu2 && copy_back_tag_read_req && !toe_tif.busy;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE, ST_LOOKUP: begin
				if (wr_take) begin
					state_nxt = ST_STROBE;
				end else if (!cpu2 && tag_lookup_active) begin
					state_nxt = ST_LOOKUP;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			ST_STROBE: begin
				state_nxt = ST_HOLD;
			end
			ST_HOLD: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_valid_r <= 1'b0;
			wr_modified_r <= 1'b0;
		end else if (wr_take) begin
			wr_valid_r <= new_line_valid;
			wr_modified_r <= new_line_modified;
		end
	end

	// Tag pins, registered from next state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tag_write_strobe_n <= PIN_LOW_ACTIVE_IDLE;
			tag_latch_output_enable_n <= PIN_LOW_ACTIVE_IDLE;
			tag_line_valid_out <= TV_RESET;
			tag_line_valid_oe <= 1'b0;
			tag_write_busy <= 1'b0;
		end else begin
			tag_write_strobe_n <= (state_nxt != ST_STROBE);
			// latch drive for lookup or write
			tag_latch_output_enable_n <= (state_nxt == ST_IDLE);
			tag_line_valid_oe <= (state_nxt != ST_IDLE);
			tag_write_busy <= (state_nxt == ST_STROBE) || (state_nxt == ST_HOLD) || wr_take;
			if (wr_take) begin
				// new valid state at selected polarity
				tag_line_valid_out <= (new_line_valid == tag_status_polarity_select);
			end else if (state_nxt == ST_LOOKUP) begin
				tag_line_valid_out <= tag_status_polarity_select;
			end else if (state_nxt == ST_IDLE) begin
				tag_line_valid_out <= TV_RESET;
			end
		end
	end

	// programmable hit delay from transfer start
	assign hit_tif.start = !cpu2 && ts_seen;
	assign hit_tif.count = hit_sample_delay;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase_open_r <= 1'b0;
		end else if (ts_seen && !cpu2) begin
			phase_open_r <= 1'b1;
		end else if (address_phase_end) begin
			phase_open_r <= 1'b0;
		end
	end

	// sample dirty input inside the valid window
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_modified <= 1'b0;
			line_status_sampled <= 1'b0;
		end else begin
			line_status_sampled <= hit_tif.expire && phase_open_r;
			if (hit_tif.expire && phase_open_r) begin
				line_modified <= (din_s2_r == tag_status_polarity_select);
			end
		end
	end

	assign toe_tif.start = cb_take;
	assign toe_tif.count = tag_read_hold_select ? TOE_CNT_W'(TOE_LONG_CYCLES) : TOE_CNT_W'(TOE_SHORT_CYCLES);

	assign req_active = cpu2 && !din_s2_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_modified_out_or_cpu2_grant <= PIN_LOW_ACTIVE_IDLE;
			tag_drive_enable_or_cpu2_data_grant_n <= PIN_LOW_ACTIVE_IDLE;
			cpu2_request_seen <= 1'b0;
		end else if (cpu2) begin
			cpu2_request_seen <= req_active;
			line_modified_out_or_cpu2_grant <= !(req_active && !higher_priority_pending);
			tag_drive_enable_or_cpu2_data_grant_n <= !(data_bus_next_free && cpu2_data_top_priority
				&& tag_drive_enable_or_cpu2_data_grant_n);
		end else begin
			cpu2_request_seen <= 1'b0;
			// new modified state, held through hold clock
			if (wr_take) begin
				line_modified_out_or_cpu2_grant <= (new_line_modified == tag_status_polarity_select);
			end
			tag_drive_enable_or_cpu2_data_grant_n <= !toe_tif.busy;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_strobe_low;
		!tag_write_strobe_n;
	endsequence

	sequence s_hold_clock;
		tag_write_strobe_n && tag_line_valid_oe && !tag_latch_output_enable_n;
	endsequence

	chk_strobe_one_clock: assert property ($fell(tag_write_strobe_n) |=> tag_write_strobe_n)
		else $error("tag write strobe longer than one clock");
	chk_write_valid_level: assert property (wr_take |=> s_strobe_low and
		(tag_line_valid_out == ($past(new_line_valid) == tag_status_polarity_select)))
		else $error("tag valid level wrong during write");
	chk_valid_hold: assert property (s_strobe_low ##1 tag_write_strobe_n |-> s_hold_clock
		and $stable(tag_line_valid_out))
		else $error("tag valid not held after strobe");
	chk_valid_release: assert property (tag_latch_output_enable_n |-> !tag_line_valid_oe)
		else $error("tag valid driven with latch disabled");
	chk_lookup_active: assert property (!cpu2 && state_r == ST_LOOKUP && !tag_write_busy
		|-> tag_line_valid_out == tag_status_polarity_select)
		else $error("tag valid not active on lookup");
	chk_dirty_hold: assert property (s_strobe_low ##1 tag_write_strobe_n |-> !cpu2 &&
		$stable(line_modified_out_or_cpu2_grant))
		else $error("dirty out not held after strobe");
	chk_toe_short: assert property (cb_take && !tag_read_hold_select |-> ##2
		(!tag_drive_enable_or_cpu2_data_grant_n)[*2] ##1 tag_drive_enable_or_cpu2_data_grant_n)
		else $error("tag drive enable not two clocks");
	chk_toe_long: assert property (cb_take && tag_read_hold_select |-> ##2
		(!tag_drive_enable_or_cpu2_data_grant_n)[*3] ##1 tag_drive_enable_or_cpu2_data_grant_n)
		else $error("tag drive enable not three clocks");
	chk_dirty_sample: assert property (hit_tif.expire && phase_open_r |=> line_status_sampled
		&& line_modified == ($past(din_s2_r) == $past(tag_status_polarity_select)))
		else $error("dirty input not sampled at delay expiry");
	chk_grant_top: assert property (req_active && !higher_priority_pending
		|=> !line_modified_out_or_cpu2_grant)
		else $error("grant missing for top priority request");
	chk_grant_withheld: assert property (cpu2 && higher_priority_pending
		|=> line_modified_out_or_cpu2_grant)
		else $error("grant given while higher priority pending");
	chk_data_grant_pulse: assert property (cpu2 && $fell(tag_drive_enable_or_cpu2_data_grant_n)
		|-> $past(data_bus_next_free) ##1 tag_drive_enable_or_cpu2_data_grant_n)
		else $error("data grant not a one clock pulse");
	chk_role_static: assert property (cpu2 |-> tag_write_strobe_n && tag_latch_output_enable_n
		&& !tag_line_valid_oe)
		else $error("tag pins used in processor mode");
endmodule : l2_tag_and_cpu2_arbitration

// ---- l2_tag_pkg.sv ----
// Purpose: Shared constants for the L2 tag / second processor pin block
// Assumes: One 40 MHz processor bus clock
// Notes: Pin levels are given as written on the wire
//
// What this block does
// - Tag write strobe low for exactly one clock per tag write.
// - Polarity select sets active level of valid, dirty in and dirty out.
// - During a tag write, valid output carries the new line valid state.
// - Valid output stays valid during strobe and one clock after it.
// - During tag lookups the valid output is driven to its active level.
// - Valid output is released whenever the latch output enable is negated.
// - Active dirty input means the selected line is modified.
// - Dirty input is valid from hit delay expiry to address phase end; sampled then.
// - Dirty output carries the new modified state of the line.
// - Dirty output stays valid during strobe and one clock after it.
// - Tag drive enable lasts two or three clocks for copy-back tag reads.
// - In second processor mode three shared pins become request, grant, data grant.
// - Grant asserted when the second processor request has top priority.
// - Grant negated while higher priority transactions are pending.
// - Delay from transfer start to dirty sampling is programmable in clocks.
// - Latch output enable asserted for tag lookups and tag writes only.
// - Data grant asserted one clock before data bus free, negated next clock.
package l2_tag_pkg;
	localparam int CLK_MHZ = 40;
	localparam int HIT_DLY_W_DEFAULT = 3;
	localparam int TWE_NS = 25;
	localparam int TWE_CYCLES = (TWE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_AFTER_CYCLES = 1;
	localparam int TOE_SHORT_CYCLES = 2;
	localparam int TOE_LONG_CYCLES = 3;
	localparam int TOE_CNT_W = 2;
	localparam logic PIN_LOW_ACTIVE_IDLE = 1'b1;
	localparam logic TV_RESET = 1'b0;
	localparam logic MODE_RESET = 1'b0;
	typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_STROBE, ST_HOLD} tag_state_e;
endpackage : l2_tag_pkg

// ---- delay_timer_if.sv ----
`timescale 1ns/100ps
// Purpose: Start/count/busy/expire handshake to a delay timer
// Assumes: Same clock on both sides
// Notes: expire is a one-cycle pulse
interface delay_timer_if #(parameter int W = 3);
	logic start;
	logic [W-1:0] count;
	logic busy;
	logic expire;
	modport ctrl (output start, output count, input busy, input expire);
	modport timer (input start, input count, output busy, output expire);
endinterface : delay_timer_if

// ---- delay_timer.sv ----
`timescale 1ns/100ps
// Purpose: Load-and-count timer; busy for count cycles, then expire pulse
// Assumes: count of zero gives an expire on the next cycle
// Notes: A start while busy restarts the count
module delay_timer import l2_tag_pkg::*; #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic reset,
	delay_timer_if.timer tif
);
	logic [W-1:0] cnt_r;
	logic busy_r;
	logic expire_r;

	if (W < 1) begin : g_bad
		$error("delay_timer: W must be at least 1");
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			expire_r <= 1'b0;
		end else if (tif.start) begin
			busy_r <= (tif.count != '0);
			expire_r <= (tif.count == '0);
			cnt_r <= tif.count - W'(1);
		end else if (busy_r) begin
			busy_r <= (cnt_r != '0);
			expire_r <= (cnt_r == '0);
			cnt_r <= cnt_r - W'(1);
		end else begin
			expire_r <= 1'b0;
		end
	end

	assign tif.busy = busy_r;
	assign tif.expire = expire_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_timer_two_cycles: assert property (tif.start && tif.count == W'(2) |=> busy_r[*2] ##1 (!busy_r && expire_r))
		else $error("timer length wrong for count two");
endmodule : delay_timer

// ---- tag_far_side_model.sv ----
// Purpose: Far side of the shared pins: tag RAM in L2 mode, second processor otherwise
// Assumes: Role is static and matches the block's role; same clock as the block
// Notes: Released tag bus shows a pattern that changes every cycle
`timescale 1ns/100ps
module tag_far_side_model #(
	parameter logic [7:0] TAG_CONTENT = 8'h5a
) (
	input wire logic clk,
	input wire logic cpu2_mode,
	input wire logic polarity,
	input wire logic modified,
	input wire logic want_bus,
	input wire logic grant_n,
	input wire logic drive_n,
	output logic dirty_or_request,
	output logic [7:0] tag_bus
);
	logic backoff_r;
	logic [7:0] idle_r;
	initial begin
		backoff_r = 1'b0;
		idle_r = 8'h0f;
	end
	// back off after taking the granted tenure
	// no retry driven here, so only grants cause back-off
	always_ff @(posedge clk) begin
		backoff_r <= cpu2_mode && !grant_n && !backoff_r;
	end
	always_ff @(posedge clk) begin
		idle_r <= ~idle_r;
	end
	assign dirty_or_request = cpu2_mode ? !(want_bus && !backoff_r) : (modified == polarity);
	assign tag_bus = (!cpu2_mode && !drive_n) ? TAG_CONTENT : idle_r;
endmodule : tag_far_side_model

// ---- l2_tag_and_cpu2_arbitration_bench.sv ----
// Purpose: Self-checking bench for the L2 tag / second processor pin block
// Assumes: Inputs driven at the falling edge, outputs read there
// Notes: Role changes need a fresh reset
`timescale 1ns/100ps
module l2_tag_and_cpu2_arbitration_bench;
	import l2_tag_pkg::*;
	logic clk, reset, cpu2_mode, pol, hold, lookup, wreq, nv, nm, cbreq, ape, hp, dnf, top, ts_n;
	logic modified, want;
	logic [HIT_DLY_W_DEFAULT-1:0] dly;
	logic pin, strobe_n, tv_out, tv_oe, latch_n, gnt, drv_n, busy, lmod, lsamp, rseen;
	logic [7:0] tag_bus;
	int errors = 0;
	int n_tests = 0;

	l2_tag_and_cpu2_arbitration DUT (.clk(clk), .reset(reset), .cpu2_mode(cpu2_mode),
		.tag_status_polarity_select(pol), .tag_read_hold_select(hold), .hit_sample_delay(dly),
		.tag_lookup_active(lookup), .tag_write_req(wreq), .new_line_valid(nv), .new_line_modified(nm),
		.copy_back_tag_read_req(cbreq), .address_phase_end(ape), .higher_priority_pending(hp),
		.data_bus_next_free(dnf), .cpu2_data_top_priority(top), .transfer_start_n(ts_n),
		.line_modified_in_or_cpu2_request(pin), .tag_write_strobe_n(strobe_n), .tag_line_valid_out(tv_out),
		.tag_line_valid_oe(tv_oe), .tag_latch_output_enable_n(latch_n), .line_modified_out_or_cpu2_grant(gnt),
		.tag_drive_enable_or_cpu2_data_grant_n(drv_n), .tag_write_busy(busy), .line_modified(lmod),
		.line_status_sampled(lsamp), .cpu2_request_seen(rseen));
	tag_far_side_model far (.clk(clk), .cpu2_mode(cpu2_mode), .polarity(pol), .modified(modified),
		.want_bus(want), .grant_n(gnt), .drive_n(drv_n), .dirty_or_request(pin), .tag_bus(tag_bus));

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: pin level %b, expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic chkn(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			errors++;
			$display("ERROR %0t: cycle count %0d, expected %0d", $time, got, exp);
		end
	endtask : chkn
	task automatic end_sim;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic do_reset(input logic mode);
		@(negedge clk);
		reset = 1'b1;
		cpu2_mode = mode;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		repeat (2) @(negedge clk);
	endtask : do_reset
	task automatic tag_write(input logic p, input logic v, input logic m);
		pol = p;
		nv = v;
		nm = m;
		wreq = 1'b1;
		@(negedge clk);
		chk1(strobe_n, 1'b0);
		chk1(busy, 1'b1);
		chk1(latch_n, 1'b0);
		chk1(tv_oe, 1'b1);
		chk1(tv_out, v == p);
		chk1(gnt, m == p);
		@(negedge clk);
		wreq = 1'b0;
		chk1(strobe_n, 1'b1);
		chk1(tv_out, v == p);
		chk1(gnt, m == p);
		@(negedge clk);
		chk1(latch_n, 1'b1);
		chk1(tv_oe, 1'b0);
		chk1(strobe_n, 1'b1);
		@(negedge clk);
	endtask : tag_write
	task automatic dirty_sample(input int d, input logic m, input logic p, input logic early);
		int at;
		at = 0;
		pol = p;
		modified = m;
		dly = d[HIT_DLY_W_DEFAULT-1:0];
		repeat (3) @(negedge clk);
		ts_n = 1'b0;
		for (int k = 1; k <= d + 8; k++) begin
			@(negedge clk);
			ape = early && k == 5;
			if (lsamp === 1'b1 && at == 0) at = k;
		end
		ts_n = 1'b1;
		chkn(at, early ? 0 : d + 4);
		if (!early) chk1(lmod, m);
		ape = 1'b1;
		@(negedge clk);
		ape = 1'b0;
	endtask : dirty_sample
	task automatic copy_back(input logic h);
		int low;
		low = 0;
		hold = h;
		cbreq = 1'b1;
		@(negedge clk);
		cbreq = 1'b0;
		repeat (7) begin
			@(negedge clk);
			if (drv_n === 1'b0) begin
				low++;
				chk1(tag_bus == 8'h5a, 1'b1);
			end
		end
		chkn(low, 2 + h);
		chk1(tag_bus == 8'h5a, 1'b0);
	endtask : copy_back

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 20000);
		errors++;
		end_sim();
	end
	initial begin
		int cnt;
		{reset, cpu2_mode, pol, hold, lookup, wreq, nv, nm, cbreq, ape, hp, dnf, top} = 13'h1000;
		ts_n = 1'b1;
		modified = 1'b0;
		want = 1'b0;
		dly = '0;
		do_reset(1'b0);
		for (int i = 0; i < 4; i++) tag_write(i[0], i[1], i[0] ^ ~i[1]);
		for (int i = 0; i < 2; i++) begin
			pol = i[0];
			lookup = 1'b1;
			@(negedge clk);
			lookup = 1'b0;
			chk1(latch_n, 1'b0);
			chk1(tv_out, i[0]);
			@(negedge clk);
			chk1(tv_oe, 1'b0);
		end
		dirty_sample(1, 1'b1, 1'b1, 1'b0);
		dirty_sample(3, 1'b0, 1'b1, 1'b0);
		dirty_sample(0, 1'b1, 1'b0, 1'b0);
		dirty_sample(3, 1'b1, 1'b1, 1'b1);
		copy_back(1'b0);
		copy_back(1'b1);
		do_reset(1'b1);
		want = 1'b1;
		cnt = 0;
		while (gnt !== 1'b0 && cnt < 10) begin
			@(negedge clk);
			cnt++;
		end
		chk1(gnt, 1'b0);
		chk1(rseen, 1'b1);
		wreq = 1'b1;
		@(negedge clk);
		wreq = 1'b0;
		@(negedge clk);
		chk1(strobe_n, 1'b1);
		hp = 1'b1;
		repeat (4) @(negedge clk);
		repeat (4) begin
			@(negedge clk);
			chk1(gnt, 1'b1);
		end
		for (int t = 0; t < 2; t++) begin
			cnt = 0;
			top = t[0];
			dnf = 1'b1;
			@(negedge clk);
			dnf = 1'b0;
			chk1(drv_n, ~t[0]);
			repeat (4) begin
				@(negedge clk);
				if (drv_n === 1'b0) cnt++;
			end
			chkn(cnt, 0);
		end
		end_sim();
	end
endmodule : l2_tag_and_cpu2_arbitration_bench
